// ### logic/tfpo_timer.sv
// Purpose: 16-bit timer with two capture/compare registers, one output pin, AXI4-Lite registers.
// Assumes: Count clock is the system clock; pins are asynchronous and synchronised here.
// Notes: Output toggles one clock after its cause; irq outputs are one-cycle pulses.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module tfpo_timer
   import tfpo_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_capture_in_primary,
   input wire logic i_capture_in_secondary,
   output logic o_timer_out_pin,
   output logic o_irq_match_a,
   output logic o_irq_match_b
);
   logic [1:0] pri_sync_reg, pri_sync_next, sec_sync_reg, sec_sync_next;
   logic pri_last_reg, pri_last_next, sec_last_reg, sec_last_next;
   logic [15:0] count_register_reg, count_register_next;
   logic [15:0] cc_reg_a_reg, cc_reg_a_next, cc_reg_b_reg, cc_reg_b_next;
   logic [1:0] mode_reg, mode_next;
   logic overflow_flag_reg, overflow_flag_next;
   logic invert_on_edge_bit_reg, invert_on_edge_bit_next;
   logic [2:0] capcomp_reg, capcomp_next;
   logic out_en_reg, out_en_next, oneshot_enable_bit_reg, oneshot_enable_bit_next;
   logic [1:0] edge_en_reg, edge_en_next;
   logic timer_out_reg, timer_out_next, irq_a_reg, irq_a_next, irq_b_reg, irq_b_next;
   logic os_trig_reg, os_trig_next;
   logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   tfpo_wr_t wr_reg, wr_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   // Bus readies come from flip-flops like every other output
   logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;

   logic pri_edge, sec_edge, wr_fire, a_cap, b_cap, match_a, match_b, running, os_mode;
   logic cap_a_evt, cap_b_evt;

   assign o_awready = awready_reg;
   assign o_wready = wready_reg;
   assign o_arready = arready_reg;
   assign o_bvalid = bvalid_reg;
   assign o_bresp = bresp_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rresp = rresp_reg;
   assign o_rdata = rdata_reg;
   assign o_timer_out_pin = timer_out_reg;
   assign o_irq_match_a = irq_a_reg;
   assign o_irq_match_b = irq_b_reg;

   // Synchronisers and edge memory; only the second stage feeds edge logic
   always_comb begin
      pri_sync_next = {pri_sync_reg[0], i_capture_in_primary};
      sec_sync_next = {sec_sync_reg[0], i_capture_in_secondary};
      pri_last_next = pri_sync_reg[1];
      sec_last_next = sec_sync_reg[1];
   end
   // Any change counts as valid; rising and falling edges both count, with no polarity select
   assign pri_edge = edge_en_reg[TFPO_EDGE_PRI_BIT] && (pri_sync_reg[1] != pri_last_reg);
   assign sec_edge = edge_en_reg[TFPO_EDGE_SEC_BIT] && (sec_sync_reg[1] != sec_last_reg);

   // Bus write capture
   // Count writes are accepted but have no effect
   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      wr_next = wr_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      if (i_awvalid && o_awready) begin
         aw_held_next = 1'b1;
         wr_next.addr = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         w_held_next = 1'b1;
         wr_next.data = i_wdata;
      end
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (wr_reg.addr[7:2] <= TFPO_OFF_CCB[7:2]) ? TFPO_RESP_OKAY : TFPO_RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
         bvalid_next = 1'b0;
      end
      // Registered from the next state, so ready tracks the held flags exactly
      awready_next = !aw_held_next && !bvalid_next;
      wready_next = !w_held_next && !bvalid_next;
   end

   // Bus read; count read returns the live count
   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (i_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next = TFPO_RESP_OKAY;
         case ({i_araddr[7:2], 2'b00})
            TFPO_OFF_MODE: rdata_next = {28'h0000000, mode_reg, invert_on_edge_bit_reg, overflow_flag_reg};
            TFPO_OFF_CAPCOMP: rdata_next = {29'h00000000, capcomp_reg};
            TFPO_OFF_OUTCTL: rdata_next = {26'h0000000, oneshot_enable_bit_reg, 4'h0, out_en_reg};
            TFPO_OFF_EDGE: rdata_next = {30'h00000000, edge_en_reg};
            TFPO_OFF_COUNT: rdata_next = {16'h0000, count_register_reg};
            TFPO_OFF_CCA: rdata_next = {16'h0000, cc_reg_a_reg};
            TFPO_OFF_CCB: rdata_next = {16'h0000, cc_reg_b_reg};
            default: begin
               rdata_next = 32'h00000000;
               rresp_next = TFPO_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && i_rready) begin
         rvalid_next = 1'b0;
      end
      // A new read waits until the previous answer is taken
      arready_next = !rvalid_next;
   end

   // Timer core
   assign running = mode_reg != TFPO_MODE_STOP;
   assign a_cap = capcomp_reg[TFPO_CC_A_CAP_BIT];
   assign b_cap = capcomp_reg[TFPO_CC_B_CAP_BIT];
   assign os_mode = oneshot_enable_bit_reg && (mode_reg == TFPO_MODE_FREE || mode_reg == TFPO_MODE_EDGE_CLR);
   assign match_a = running && !a_cap && (count_register_reg == cc_reg_a_reg);
   assign match_b = running && !b_cap && (count_register_reg == cc_reg_b_reg);
   // A picks its trigger; B only ever sees the primary pin
   assign cap_a_evt = running && a_cap
      && (capcomp_reg[TFPO_CC_A_SEC_BIT] ? sec_edge : pri_edge);
   assign cap_b_evt = running && b_cap && pri_edge;

   always_comb begin
      logic restart;
      logic toggle;
      restart = 1'b0;
      toggle = 1'b0;
      count_register_next = count_register_reg;
      cc_reg_a_next = cc_reg_a_reg;
      cc_reg_b_next = cc_reg_b_reg;
      mode_next = mode_reg;
      overflow_flag_next = overflow_flag_reg;
      invert_on_edge_bit_next = invert_on_edge_bit_reg;
      capcomp_next = capcomp_reg;
      out_en_next = out_en_reg;
      oneshot_enable_bit_next = oneshot_enable_bit_reg;
      edge_en_next = edge_en_reg;
      os_trig_next = 1'b0;
      // Trigger lives one cycle and acts the cycle after the write
      // Software writes first, so hardware events below win over them
      // A flag clear in the same cycle as an overflow therefore loses
      if (wr_fire) begin
         case ({wr_reg.addr[7:2], 2'b00})
            TFPO_OFF_MODE: if (i_wstrb[0] || 1'b1) begin
               mode_next = wr_reg.data[TFPO_MODE_LO_BIT +: 2];
               invert_on_edge_bit_next = wr_reg.data[TFPO_MODE_INV_BIT];
               overflow_flag_next = wr_reg.data[TFPO_MODE_OVF_BIT];
            end
            TFPO_OFF_CAPCOMP: capcomp_next = wr_reg.data[2:0];
            TFPO_OFF_OUTCTL: begin
               out_en_next = wr_reg.data[TFPO_OC_OUT_EN_BIT];
               oneshot_enable_bit_next = wr_reg.data[TFPO_OC_OS_EN_BIT];
               os_trig_next = wr_reg.data[TFPO_OC_OS_TRIG_BIT]; // Self-clearing
            end
            TFPO_OFF_EDGE: edge_en_next = wr_reg.data[1:0];
            TFPO_OFF_CCA: cc_reg_a_next = wr_reg.data[15:0];
            TFPO_OFF_CCB: cc_reg_b_next = wr_reg.data[15:0];
            default: ;
         endcase
      end
      if (!running) begin
         count_register_next = TFPO_COUNT_ZERO;
      end else begin
         if (mode_reg == TFPO_MODE_PPG && match_a) begin
            count_register_next = TFPO_COUNT_ZERO;
         end else begin
            count_register_next = count_register_reg + 16'h0001;
            if (count_register_reg == TFPO_COUNT_MAX) begin
               overflow_flag_next = 1'b1;
            end
         end
         // Primary edge restarts in edge-clear mode; one-shot needs it too
         if (os_mode && (os_trig_reg || pri_edge)) begin
            restart = 1'b1;
         end else if (mode_reg == TFPO_MODE_EDGE_CLR && pri_edge) begin
            restart = 1'b1;
         end
         if (restart) begin
            count_register_next = TFPO_COUNT_ZERO;
         end
      end
      if (cap_a_evt) begin
         cc_reg_a_next = count_register_reg;
      end
      if (cap_b_evt) begin
         cc_reg_b_next = count_register_reg;
      end
      // Matches bound the pulse in every compare mode
      toggle = (match_a ^ match_b) && !restart;
      if (a_cap && b_cap && invert_on_edge_bit_reg && pri_edge) begin
         toggle = 1'b1;
      end
      timer_out_next = timer_out_reg ^ toggle;
      // Pulse-gen uses fixed levels, so the first period cannot come out inverted
      // Pin is frozen low while the secondary edge is in use
      if (!out_en_reg || edge_en_reg[TFPO_EDGE_SEC_BIT]) begin
         timer_out_next = 1'b0;
      end else if (mode_reg == TFPO_MODE_PPG && match_a) begin
         timer_out_next = 1'b1;
      end else if (mode_reg == TFPO_MODE_PPG && match_b) begin
         timer_out_next = 1'b0;
      end
      irq_a_next = match_a || (cap_a_evt && capcomp_reg[TFPO_CC_A_SEC_BIT]);
      irq_b_next = match_b || cap_b_evt;
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pri_sync_reg <= 2'h0;
         sec_sync_reg <= 2'h0;
         pri_last_reg <= 1'b0;
         sec_last_reg <= 1'b0;
         count_register_reg <= TFPO_COUNT_ZERO;
         cc_reg_a_reg <= TFPO_COUNT_ZERO;
         cc_reg_b_reg <= TFPO_COUNT_ZERO;
         mode_reg <= TFPO_MODE_STOP;
         overflow_flag_reg <= 1'b0;
         invert_on_edge_bit_reg <= 1'b0;
         capcomp_reg <= 3'h0;
         out_en_reg <= 1'b0;
         oneshot_enable_bit_reg <= 1'b0;
         edge_en_reg <= 2'h0;
         timer_out_reg <= 1'b0;
         irq_a_reg <= 1'b0;
         irq_b_reg <= 1'b0;
         os_trig_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wr_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= TFPO_RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= TFPO_RESP_OKAY;
         rdata_reg <= 32'h00000000;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         arready_reg <= 1'b1;
      end else begin
         pri_sync_reg <= pri_sync_next;
         sec_sync_reg <= sec_sync_next;
         pri_last_reg <= pri_last_next;
         sec_last_reg <= sec_last_next;
         count_register_reg <= count_register_next;
         cc_reg_a_reg <= cc_reg_a_next;
         cc_reg_b_reg <= cc_reg_b_next;
         mode_reg <= mode_next;
         overflow_flag_reg <= overflow_flag_next;
         invert_on_edge_bit_reg <= invert_on_edge_bit_next;
         capcomp_reg <= capcomp_next;
         out_en_reg <= out_en_next;
         oneshot_enable_bit_reg <= oneshot_enable_bit_next;
         edge_en_reg <= edge_en_next;
         timer_out_reg <= timer_out_next;
         irq_a_reg <= irq_a_next;
         irq_b_reg <= irq_b_next;
         os_trig_reg <= os_trig_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         wr_reg <= wr_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         arready_reg <= arready_next;
      end
   end
endmodule

// ### logic/tfpo_pkg.sv
// Purpose: Constants and types for the 16-bit free-run / pulse-gen / one-shot timer.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:
// Notes on behaviour
// - Mode 01: count up, never clear on match
// - After FFFF: set overflow, wrap, keep counting
// - Each register compare or capture, independently
// - Register A match raises irq A, no clear
// - Register B match raises irq B, no clear
// - A captures on primary or secondary edge
// - B captures only on primary edge
// - Output unavailable while secondary edges used
// - Both compare: toggle and irq per match
// - Capture into B raises irq B
// - Both capture: toggle on primary only if invert
// - Secondary-only edges: B gets no captures
// - Mode 11: clear on A match, period A+1
// - Pulse-gen output active B+1 clocks per period
// - One-shot enabled in mode 01/10 with bit 5
// - Trigger bit 6 or primary edge restarts counter
// - Counter read returns current count
// - One-shot: each match raises irq and toggles
// - Pulse starts M+1 after trigger, lasts N-M
package tfpo_pkg;
   localparam logic [7:0] TFPO_OFF_MODE = 8'h00;
   localparam logic [7:0] TFPO_OFF_CAPCOMP = 8'h04;
   localparam logic [7:0] TFPO_OFF_OUTCTL = 8'h08;
   localparam logic [7:0] TFPO_OFF_EDGE = 8'h0C;
   localparam logic [7:0] TFPO_OFF_COUNT = 8'h10;
   localparam logic [7:0] TFPO_OFF_CCA = 8'h14;
   localparam logic [7:0] TFPO_OFF_CCB = 8'h18;
   // Mode register fields
   localparam int TFPO_MODE_OVF_BIT = 0;
   localparam int TFPO_MODE_INV_BIT = 1;
   localparam int TFPO_MODE_LO_BIT = 2;
   // Capture/compare control fields
   localparam int TFPO_CC_A_CAP_BIT = 0;
   localparam int TFPO_CC_A_SEC_BIT = 1;
   localparam int TFPO_CC_B_CAP_BIT = 2;
   // Output control fields
   localparam int TFPO_OC_OUT_EN_BIT = 0;
   localparam int TFPO_OC_OS_EN_BIT = 5;
   localparam int TFPO_OC_OS_TRIG_BIT = 6;
   // Edge enable fields
   localparam int TFPO_EDGE_PRI_BIT = 0;
   localparam int TFPO_EDGE_SEC_BIT = 1;
   localparam logic [15:0] TFPO_COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] TFPO_COUNT_ZERO = 16'h0000;
   localparam logic [1:0] TFPO_RESP_OKAY = 2'h0;
   localparam logic [1:0] TFPO_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      TFPO_MODE_STOP = 2'b00,
      TFPO_MODE_FREE = 2'b01,
      TFPO_MODE_EDGE_CLR = 2'b10,
      TFPO_MODE_PPG = 2'b11
   } tfpo_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } tfpo_wr_t;
endpackage

// ### testbench/tfpo_timer_monitor.sv
// Purpose: Port-level checks of the timer: bus handshakes and event outputs.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Irq pulses and output toggles share one edge.
`timescale 1ns/1ps
module tfpo_timer_monitor (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic o_timer_out_pin,
   input wire logic o_irq_match_a,
   input wire logic o_irq_match_b
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   a_irq_a_single: assert property (o_irq_match_a |=> !o_irq_match_a)
      else $error("irq a wider than one cycle");
   a_irq_b_single: assert property (o_irq_match_b |=> !o_irq_match_b)
      else $error("irq b wider than one cycle");
   // Every toggle of the pin must come with the match or capture that caused it
   a_out_has_cause: assert property ($changed(o_timer_out_pin) |-> o_irq_match_a || o_irq_match_b)
      else $error("output moved without an event");
   a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
      else $error("write response late");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read response late");
   a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped early");
   a_aw_refused: assert property (o_bvalid |-> !o_awready)
      else $error("address taken while response pending");
   a_ar_refused: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while data pending");
   c_irq_a: cover property (o_irq_match_a);
   c_irq_b: cover property (o_irq_match_b);
   c_out_rise: cover property ($rose(o_timer_out_pin));
endmodule

bind tfpo_timer tfpo_timer_monitor i_mon (.i_clock, .i_reset_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
   .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_timer_out_pin,
   .o_irq_match_a, .o_irq_match_b);

// ### testbench/tfpo_pin_source.sv
// Purpose: Far-side source of both capture pins.
// Assumes: Pins are always driven, no pull.
// Notes: Levels change only on request, so a software trigger sees a steady pin.
`timescale 1ns/1ps
module tfpo_pin_source (
   input wire logic i_clock,
   output logic o_primary,
   output logic o_secondary
);
   initial begin
      o_primary = 1'b0;
      o_secondary = 1'b0;
   end
   // Held level between requests
   task automatic flip(input logic which);
      @(posedge i_clock);
      if (which) o_secondary <= ~o_secondary;
      else o_primary <= ~o_primary;
   endtask
endmodule

// ### testbench/tfpo_timer_bench.sv
// Purpose: Self-checking bench of the timer over AXI4-Lite and its pins.
// Assumes: Count clock equals the system clock.
// Notes: Event counters sample on the falling edge, clear of update races.
`timescale 1ns/1ps
module tfpo_timer_bench;
   import tfpo_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} tfpo_row_t;
   logic i_clock = 0, i_reset_n = 0, pri, sec;
   logic [7:0] i_awaddr = 0, i_araddr = 0;
   logic [31:0] i_wdata = 0, o_rdata, q, q2;
   logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_timer_out_pin, o_irq_match_a, o_irq_match_b;
   logic [1:0] o_bresp, o_rresp, r;
   int n_mismatch = 0, checked = 0, cyc = 0, n_hi, n_ia, n_ib;
   tfpo_row_t rows [8] = '{'{TFPO_OFF_CCA, 32'h1234, 32'h1234, TFPO_RESP_OKAY},
      '{TFPO_OFF_CCB, 32'hABCD, 32'hABCD, TFPO_RESP_OKAY}, '{TFPO_OFF_CAPCOMP, 32'h5, 32'h5, TFPO_RESP_OKAY},
      '{TFPO_OFF_EDGE, 32'h2, 32'h2, TFPO_RESP_OKAY}, '{TFPO_OFF_OUTCTL, 32'h61, 32'h21, TFPO_RESP_OKAY},
      '{TFPO_OFF_MODE, 32'h2, 32'h2, TFPO_RESP_OKAY}, '{TFPO_OFF_COUNT, 32'h5, 32'h0, TFPO_RESP_OKAY},
      '{8'h1C, 32'hFF, 32'h0, TFPO_RESP_SLVERR}};
   tfpo_timer i_dut (.i_clock, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb(4'hF),
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
      .o_rresp, .o_rvalid, .i_rready, .i_capture_in_primary(pri), .i_capture_in_secondary(sec),
      .o_timer_out_pin, .o_irq_match_a, .o_irq_match_b);
   tfpo_pin_source i_src (.i_clock, .o_primary(pri), .o_secondary(sec));
   always #2 i_clock = ~i_clock;
   always @(negedge i_clock) begin
      cyc++;
      n_hi += int'(o_timer_out_pin === 1'b1);
      n_ia += int'(o_irq_match_a === 1'b1);
      n_ib += int'(o_irq_match_b === 1'b1);
      if (cyc == 90000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask
   // Request held until its own handshake edge; ends one edge later
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_go, w_go, done;
      done = 0;
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_bready <= 1;
      while (!done) begin
         @(negedge i_clock);
         aw_go = i_awvalid && o_awready;
         w_go = i_wvalid && o_wready;
         done = o_bvalid;
         r = o_bresp;
         @(posedge i_clock);
         if (aw_go) i_awvalid <= 0;
         if (w_go) i_wvalid <= 0;
      end
      i_bready <= 0;
      @(posedge i_clock);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ar_go, done;
      done = 0;
      i_araddr <= a;
      i_arvalid <= 1;
      i_rready <= 1;
      while (!done) begin
         @(negedge i_clock);
         ar_go = i_arvalid && o_arready;
         done = o_rvalid;
         d = o_rdata;
         r = o_rresp;
         @(posedge i_clock);
         if (ar_go) i_arvalid <= 0;
      end
      i_rready <= 0;
      @(posedge i_clock);
   endtask
   task automatic rst;
      i_reset_n <= 0;
      repeat (3) @(posedge i_clock);
      i_reset_n <= 1;
      @(posedge i_clock);
   endtask
   task automatic clr;
      n_hi = 0;
      n_ia = 0;
      n_ib = 0;
   endtask
   initial begin
      repeat (16) @(posedge i_clock);
      i_reset_n <= 1;
      @(posedge i_clock);
      check_bit(o_timer_out_pin, 1'b0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         check_word({30'h0, r}, {30'h0, rows[i].r});
         rd(rows[i].a, q);
         check_word({30'h0, r}, {30'h0, rows[i].r});
         check_word(q, rows[i].q);
      end
      $display("register rows done");
      rst();
      wr(TFPO_OFF_CCA, 32'h40);
      wr(TFPO_OFF_CCB, 32'h80);
      wr(TFPO_OFF_OUTCTL, 32'h1);
      wr(TFPO_OFF_MODE, 32'h4);
      clr();
      repeat (65568) @(posedge i_clock);
      check_word(n_ia, 1);
      check_word(n_ib, 1);
      check_word(n_hi, 32'h40);
      rd(TFPO_OFF_MODE, q);
      check_word(q, 32'h5);
      wr(TFPO_OFF_MODE, 32'h4);
      rd(TFPO_OFF_MODE, q);
      check_word(q, 32'h4);
      rd(TFPO_OFF_COUNT, q);
      rd(TFPO_OFF_COUNT, q2);
      check_bit(q2 > q, 1'b1);
      $display("free-run compare done");
      rst();
      wr(TFPO_OFF_CAPCOMP, 32'h5);
      wr(TFPO_OFF_OUTCTL, 32'h1);
      wr(TFPO_OFF_EDGE, 32'h1);
      wr(TFPO_OFF_MODE, 32'h6);
      repeat (20) @(posedge i_clock);
      clr();
      i_src.flip(1'b0);
      repeat (10) @(posedge i_clock);
      check_word(n_ib, 1);
      check_bit(o_timer_out_pin, 1'b1);
      rd(TFPO_OFF_CCA, q);
      rd(TFPO_OFF_CCB, q2);
      check_word(q, q2);
      check_bit(q2 > 32'h14, 1'b1);
      rst();
      wr(TFPO_OFF_CAPCOMP, 32'h7);
      wr(TFPO_OFF_OUTCTL, 32'h1);
      wr(TFPO_OFF_EDGE, 32'h2);
      wr(TFPO_OFF_CCB, 32'h77);
      wr(TFPO_OFF_MODE, 32'h6);
      repeat (20) @(posedge i_clock);
      clr();
      i_src.flip(1'b1);
      repeat (10) @(posedge i_clock);
      check_word(n_ia, 1);
      check_word(n_ib, 0);
      check_bit(o_timer_out_pin, 1'b0);
      rd(TFPO_OFF_CCB, q);
      check_word(q, 32'h77);
      $display("capture done");
      rst();
      wr(TFPO_OFF_CCA, 32'h9);
      wr(TFPO_OFF_CCB, 32'h3);
      wr(TFPO_OFF_OUTCTL, 32'h1);
      wr(TFPO_OFF_MODE, 32'hC);
      repeat (30) @(posedge i_clock);
      clr();
      repeat (100) @(posedge i_clock);
      check_word(n_hi, 40);
      check_word(n_ia, 10);
      $display("pulse generator done");
      rst();
      wr(TFPO_OFF_CCA, 32'h5);
      wr(TFPO_OFF_CCB, 32'hC);
      wr(TFPO_OFF_MODE, 32'h4);
      repeat (50) @(posedge i_clock);
      wr(TFPO_OFF_OUTCTL, 32'h21);
      clr();
      wr(TFPO_OFF_OUTCTL, 32'h61);
      repeat (200) @(posedge i_clock);
      check_word(n_hi, 7);
      check_word(n_ia + n_ib, 2);
      wr(TFPO_OFF_EDGE, 32'h1);
      clr();
      // Pin edge only after the previous pulse has ended
      i_src.flip(1'b0);
      repeat (200) @(posedge i_clock);
      check_word(n_hi, 7);
      $display("one-shot done");
      end_sim();
   end
endmodule
